// *** dv/flash_write_status_reporter_tb_top.sv ***
// directed bench for the flash status poller against a flash model
// assumes fwsr_pkg compiled first; inputs change on the falling edge
`timescale 1ns/1ps
module flash_write_status_reporter_tb_top;
  logic        sys_clk   = 1'b0;
  logic        rst_n     = 1'b0;
  logic        req_valid = 1'b0;
  logic [1:0]  req_op    = 2'h0;
  logic [20:0] req_addr  = 21'h000000;
  logic [7:0]  req_data  = 8'h00;
  logic        req_ready, res_valid, res_late, dev_ready, flash_doe, flash_ce_n, flash_oe_n, flash_we_n, pull_low;
  logic [1:0]  res_code;
  logic [7:0]  res_status, flash_dout, flash_din;
  logic [20:0] flash_addr;
  wire         flash_ready_busy = ~pull_low; // open drain with pull-up
  int          mismatches = 0;
  int          tests_run  = 0;
  int          cyc        = 0;
  int          r0, w0;
  always #10 sys_clk = ~sys_clk;
  fwsr_host uut (.sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid), .req_op(req_op),
    .req_addr(req_addr), .req_data(req_data), .req_ready(req_ready), .res_valid(res_valid),
    .res_code(res_code), .res_status(res_status), .res_late(res_late), .dev_ready(dev_ready),
    .flash_addr(flash_addr), .flash_din(flash_din), .flash_dout(flash_dout), .flash_doe(flash_doe),
    .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
    .flash_ready_busy(flash_ready_busy));
  fwsr_flash_model dev (.addr(flash_addr), .wdata(flash_dout), .ce_n(flash_ce_n), .oe_n(flash_oe_n),
    .we_n(flash_we_n), .rdata(flash_din), .pull_low(pull_low));
  // ==========================================================
  // tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic run(input logic [1:0] op, input logic [20:0] a, input logic [7:0] d);
    int n;
    n = 0;
    r0 = dev.reads;
    w0 = dev.writes;
    @(negedge sys_clk);
    while (req_ready !== 1'b1 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    req_valid = 1'b1;
    req_op = op;
    req_addr = a;
    req_data = d;
    @(negedge sys_clk);
    req_valid = 1'b0;
    while (res_valid !== 1'b1 && n < 400) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 400) chk("answer", 32'h1, 32'h0);
  endtask
  task automatic conclude();
    $display("counts: %0d compared, %0d mismatches", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // hang guard, whole run needs well under 5000 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      conclude();
    end
  end
  // ==========================================================
  // tests
  initial begin
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    run(fwsr_pkg::OP_POLL, 21'h010000, 8'h00);
    chk("code", 32'(fwsr_pkg::RES_DONE), 32'(res_code));
    chk("reads", 32'd2, 32'(dev.reads - r0));
    chk("poll bit", 32'h1, 32'(res_status[fwsr_pkg::POLL_BIT]));
    $display("test idle poll done");
    dev.left = 3;
    run(fwsr_pkg::OP_POLL, 21'h010000, 8'h00);
    chk("code", 32'(fwsr_pkg::RES_DONE), 32'(res_code));
    chk("reads", 32'd5, 32'(dev.reads - r0));
    dev.left = 100;
    repeat (5) @(negedge sys_clk);
    chk("busy", 32'h0, 32'(dev_ready));
    dev.left = 0;
    repeat (5) @(negedge sys_clk);
    chk("ready", 32'h1, 32'(dev_ready));
    $display("test busy poll done");
    dev.susp = 1'b1;
    dev.left = 50;
    run(fwsr_pkg::OP_POLL, 21'h010000, 8'h00);
    chk("code", 32'(fwsr_pkg::RES_DONE), 32'(res_code));
    chk("reads", 32'd2, 32'(dev.reads - r0));
    chk("poll bit", 32'h1, 32'(res_status[fwsr_pkg::POLL_BIT]));
    chk("ready", 32'h1, 32'(dev_ready));
    dev.left = 0;
    dev.susp = 1'b0;
    $display("test suspend poll done");
    dev.tl = 1'b1;
    run(fwsr_pkg::OP_POLL, 21'h010000, 8'h00);
    chk("code", 32'(fwsr_pkg::RES_FAIL), 32'(res_code));
    chk("reads", 32'd3, 32'(dev.reads - r0));
    run(fwsr_pkg::OP_WRITE, 21'h000555, 8'haa);
    chk("code", 32'(fwsr_pkg::RES_FAIL), 32'(res_code));
    chk("writes", 32'd0, 32'(dev.writes - w0));
    run(fwsr_pkg::OP_ADD, 21'h020000, 8'h30);
    chk("code", 32'(fwsr_pkg::RES_FAIL), 32'(res_code));
    chk("writes", 32'd0, 32'(dev.writes - w0));
    run(fwsr_pkg::OP_RESET, 21'h012345, 8'h00);
    chk("code", 32'(fwsr_pkg::RES_DONE), 32'(res_code));
    chk("cmd", 32'hf0, 32'(dev.last_wd));
    run(fwsr_pkg::OP_WRITE, 21'h000555, 8'haa);
    chk("code", 32'(fwsr_pkg::RES_DONE), 32'(res_code));
    chk("waddr", 32'h555, 32'(dev.last_wa));
    $display("test time limit done");
    run(fwsr_pkg::OP_ADD, 21'h020000, 8'h30);
    chk("code", 32'(fwsr_pkg::RES_DONE), 32'(res_code));
    chk("writes", 32'd1, 32'(dev.writes - w0));
    run(fwsr_pkg::OP_ADD, 21'h030000, 8'h30);
    chk("late", 32'h0, 32'(res_late));
    repeat (2600) @(negedge sys_clk);
    run(fwsr_pkg::OP_ADD, 21'h040000, 8'h30);
    chk("late", 32'h1, 32'(res_late));
    dev.shut = 1'b1;
    run(fwsr_pkg::OP_ADD, 21'h060000, 8'h30);
    chk("code", 32'(fwsr_pkg::RES_WIN), 32'(res_code));
    chk("writes", 32'd1, 32'(dev.writes - w0));
    dev.win = 1'b1;
    run(fwsr_pkg::OP_ADD, 21'h050000, 8'h30);
    chk("code", 32'(fwsr_pkg::RES_WIN), 32'(res_code));
    $display("test add sector done");
    conclude();
  end
endmodule

// *** dv/fwsr_flash_model.sv ***
// behavioural flash status side; no clock, cycles framed by ce/oe/we
// assumes the bench sets left/tl/win/susp/shut and pulls the busy line up
`timescale 1ns/1ps
module fwsr_flash_model (
  input wire logic [20:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic        ce_n,
  input wire logic        oe_n,
  input wire logic        we_n,
  output logic [7:0]      rdata,
  output logic            pull_low
);
  // ==========================================================
  // status state
  int          left    = 0; // reads left to toggle, then steady status
  int          reads   = 0;
  int          writes  = 0;
  logic        tl      = 1'b0;
  logic        win     = 1'b0;
  logic        susp    = 1'b0; // erase suspended
  logic        shut    = 1'b0; // a write closes the window
  logic        tog     = 1'b0;
  logic [7:0]  held    = 8'h00;
  logic [7:0]  last_wd = 8'h00;
  logic [20:0] last_wa = 21'h000000;
  wire         rd_n    = ce_n | oe_n;
  wire         wr_n    = ce_n | we_n;
  wire  [7:0]  stat    = {~((left > 0 || tl) && !susp), tog, tl, 1'b0, win, tog, 2'b00};
  // released bus shows the inverse, not the old value
  assign rdata    = rd_n ? ~held : stat;
  assign pull_low = ((left > 0) || tl) && !susp;
  always @(posedge rd_n) begin
    held = stat;
    reads = reads + 1;
    if ((left > 0 || tl) && !susp) begin
      tog = ~tog;
    end
    if (left > 0) begin
      left = left - 1;
    end
  end
  always @(posedge wr_n) begin
    if (oe_n && !win) begin
      writes = writes + 1;
      last_wd = wdata;
      last_wa = addr;
      if (shut) begin
        win = 1'b1;
      end
      if (wdata == 8'hf0) begin
        tl = 1'b0;
      end
    end
  end
endmodule

// *** dv/fwsr_host_monitor.sv ***
// concurrent checks on the flash status poller ports
// assumes bind onto fwsr_host, one clock domain, rst_n as disable
`timescale 1ns/1ps
module fwsr_host_monitor (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        req_valid,
  input wire logic [1:0]  req_op,
  input wire logic        req_ready,
  input wire logic        res_valid,
  input wire logic        dev_ready,
  input wire logic [20:0] flash_addr,
  input wire logic [7:0]  flash_dout,
  input wire logic        flash_doe,
  input wire logic        flash_ce_n,
  input wire logic        flash_oe_n,
  input wire logic        flash_we_n,
  input wire logic        flash_ready_busy
);
  // ==========================================================
  // properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_rd_len;
    $fell(flash_oe_n) |-> (!flash_oe_n && !flash_ce_n && !flash_doe)[*5] ##1 flash_oe_n;
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("read strobe length wrong");
  property p_addr_hold;
    !flash_oe_n && $past(!flash_oe_n) |-> $stable(flash_addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved in read");
  property p_wr_len;
    $fell(flash_we_n) |-> (!flash_we_n && flash_doe && flash_oe_n)[*3] ##1 flash_we_n;
  endproperty
  a_wr_len: assert property (p_wr_len) else $error("write strobe length wrong");
  property p_wr_frame;
    !flash_we_n |-> !flash_ce_n && flash_oe_n;
  endproperty
  a_wr_frame: assert property (p_wr_frame) else $error("write without chip select");
  property p_res_pulse;
    res_valid |=> !res_valid;
  endproperty
  a_res_pulse: assert property (p_res_pulse) else $error("result longer than a cycle");
  property p_poll_start;
    req_valid && req_ready && req_op == fwsr_pkg::OP_POLL |-> ##[1:3] $fell(flash_oe_n);
  endproperty
  a_poll_start: assert property (p_poll_start) else $error("poll did not start a read");
  property p_idle_quiet;
    req_ready |-> flash_oe_n && flash_we_n && !flash_doe;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("bus active while idle");
  property p_reset_cmd;
    req_valid && req_ready && req_op == fwsr_pkg::OP_RESET |-> ##[1:4] ($fell(flash_we_n)
      && flash_dout == fwsr_pkg::RESET_CMD_DATA && flash_addr == fwsr_pkg::RESET_CMD_ADDR);
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) else $error("reset command not written");
  property p_busy_seen;
    $fell(flash_ready_busy) |-> ##[1:3] !dev_ready;
  endproperty
  a_busy_seen: assert property (p_busy_seen) else $error("busy pin not mirrored");
endmodule
bind fwsr_host fwsr_host_monitor u_mon (.sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid),
  .req_op(req_op), .req_ready(req_ready), .res_valid(res_valid), .dev_ready(dev_ready),
  .flash_addr(flash_addr), .flash_dout(flash_dout), .flash_doe(flash_doe), .flash_ce_n(flash_ce_n),
  .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_ready_busy(flash_ready_busy));

// *** hdl/fwsr_host.sv ***
// host controller that polls the flash write status and issues status-related writes
// assumes the flash pins are wired straight to the outputs; the flash data bus is
// split into din / dout / doe, and inputs are synchronous to sys_clk
//
// What this block does
// - host reads status twice in a row; equal toggles mean done
// - toggling with time limit high: recheck, still toggling means fail, reset is left to the user
// - host restarts double read whenever it resumes polling
// - after time limit failure host rejects write and add commands with fail until a reset is requested
// - valid polling and sector flags need a valid address from host
// - host checks erase window before and after each added sector
// - each added sector load starts within 50 us of prior write; host only flags a later start on res_late
`timescale 1ns/1ps
module fwsr_host (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // user side
  input  wire logic        req_valid,
  input  wire logic [1:0]  req_op,
  input  wire logic [20:0] req_addr,
  input  wire logic [7:0]  req_data,
  output logic             req_ready,
  output logic             res_valid,
  output logic [1:0]       res_code,
  output logic [7:0]       res_status,
  output logic             res_late,
  output logic             dev_ready,
  // flash pins
  output logic [20:0]      flash_addr,
  input  wire logic [7:0]  flash_din,
  output logic [7:0]       flash_dout,
  output logic             flash_doe,
  output logic             flash_ce_n,
  output logic             flash_oe_n,
  output logic             flash_we_n,
  input  wire logic        flash_ready_busy
);
  // ==========================================================
  // reset release
  logic [1:0] rst_sync_reg;
  logic       rst_int_n;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_int_n = rst_sync_reg[1];

  // ==========================================================
  // state
  typedef struct packed {
    fwsr_pkg::fwsr_state_t st;
    fwsr_pkg::fwsr_phase_t ph;
    logic [7:0]            cnt;
    logic [7:0]            first;
    logic [20:0]           addr;
    logic [7:0]            wdata;
    logic [15:0]           win_cnt;
    logic                  failed;
    logic                  add_op;
    logic                  req_ready;
    logic                  res_valid;
    logic [1:0]            res_code;
    logic [7:0]            res_status;
    logic                  res_late;
    logic                  dev_ready;
    logic [20:0]           flash_addr;
    logic [7:0]            flash_dout;
    logic                  flash_doe;
    logic                  flash_ce_n;
    logic                  flash_oe_n;
    logic                  flash_we_n;
  } fwsr_regs_t;

  fwsr_regs_t s_reg;
  fwsr_regs_t s_next;

  // operation toggle bit (OP_TOGGLE_BIT) differs between two reads
  function automatic logic toggled(input logic [7:0] a, input logic [7:0] b);
    toggled = (a[fwsr_pkg::OP_TOGGLE_BIT] != b[fwsr_pkg::OP_TOGGLE_BIT]);
  endfunction

  always_comb begin
    s_next           = s_reg;
    s_next.res_valid = 1'b0;
    s_next.dev_ready = flash_ready_busy;
    // window counter runs from the rising edge of every write
    if (s_reg.win_cnt != 16'h0000) begin
      s_next.win_cnt = s_reg.win_cnt - 16'h0001;
    end
    case (s_reg.st)
      fwsr_pkg::ST_IDLE: begin
        if (req_valid && s_reg.req_ready) begin
          s_next.req_ready  = 1'b0;
          s_next.addr       = req_addr;
          s_next.wdata      = req_data;
          s_next.flash_addr = req_addr;
          s_next.add_op     = (req_op == fwsr_pkg::OP_ADD);
          s_next.cnt        = fwsr_pkg::CNT_ZERO;
          case (req_op)
            fwsr_pkg::OP_POLL: begin
              s_next.ph = fwsr_pkg::PH_FIRST;
              s_next.st = fwsr_pkg::ST_RD;
            end
            fwsr_pkg::OP_ADD: begin
              if (s_reg.failed) begin
                s_next.res_code = fwsr_pkg::RES_FAIL;
                s_next.st       = fwsr_pkg::ST_DONE;
              end else begin
                s_next.ph = fwsr_pkg::PH_PRE;
                s_next.st = fwsr_pkg::ST_RD;
              end
            end
            fwsr_pkg::OP_RESET: begin
              s_next.ph         = fwsr_pkg::PH_WRITE;
              s_next.wdata      = fwsr_pkg::RESET_CMD_DATA;
              s_next.flash_addr = fwsr_pkg::RESET_CMD_ADDR;
              s_next.st         = fwsr_pkg::ST_WR;
            end
            default: begin
              // writes fail at once after a failure until a reset is written
              if (s_reg.failed) begin
                s_next.res_code = fwsr_pkg::RES_FAIL;
                s_next.st       = fwsr_pkg::ST_DONE;
              end else begin
                s_next.ph = fwsr_pkg::PH_WRITE;
                s_next.st = fwsr_pkg::ST_WR;
              end
            end
          endcase
        end
      end
      fwsr_pkg::ST_RD: begin
        s_next.flash_ce_n = 1'b0;
        s_next.flash_oe_n = 1'b0;
        s_next.cnt        = s_reg.cnt + 8'h01;
        if (s_reg.cnt == fwsr_pkg::READ_CYC_C) begin
          // sample at the end of the access; the strobe rise ends the read cycle
          s_next.flash_ce_n = 1'b1;
          s_next.flash_oe_n = 1'b1;
          s_next.cnt        = fwsr_pkg::CNT_ZERO;
          s_next.res_status = flash_din;
          s_next.st         = fwsr_pkg::ST_RD_GAP;
          case (s_reg.ph)
            fwsr_pkg::PH_FIRST: begin
              s_next.first = flash_din;
              s_next.ph    = fwsr_pkg::PH_SECOND;
            end
            fwsr_pkg::PH_SECOND: begin
              if (!toggled(s_reg.first, flash_din)) begin
                s_next.res_code = fwsr_pkg::RES_DONE;
                s_next.st       = fwsr_pkg::ST_DONE;
              end else if (flash_din[fwsr_pkg::TIME_LIMIT_BIT]) begin
                s_next.first = flash_din;
                s_next.ph    = fwsr_pkg::PH_RECHK;
              end else begin
                // still busy: keep polling pairwise
                s_next.first = flash_din;
              end
            end
            fwsr_pkg::PH_RECHK: begin
              if (!toggled(s_reg.first, flash_din)) begin
                s_next.res_code = fwsr_pkg::RES_DONE;
              end else begin
                s_next.res_code = fwsr_pkg::RES_FAIL;
                s_next.failed   = 1'b1;
              end
              s_next.st = fwsr_pkg::ST_DONE;
            end
            fwsr_pkg::PH_PRE: begin
              if (flash_din[fwsr_pkg::ERASE_WIN_BIT]) begin
                s_next.res_code = fwsr_pkg::RES_WIN;
                s_next.st       = fwsr_pkg::ST_DONE;
              end else begin
                s_next.res_late = (s_reg.win_cnt == 16'h0000);
                s_next.ph       = fwsr_pkg::PH_WRITE;
              end
            end
            fwsr_pkg::PH_POST: begin
              // high on the second check: the added sector may be lost
              s_next.res_code = flash_din[fwsr_pkg::ERASE_WIN_BIT] ? fwsr_pkg::RES_WIN : fwsr_pkg::RES_DONE;
              s_next.st       = fwsr_pkg::ST_DONE;
            end
            default: begin
              s_next.st = fwsr_pkg::ST_DONE;
            end
          endcase
        end
      end
      fwsr_pkg::ST_RD_GAP: begin
        s_next.cnt = s_reg.cnt + 8'h01;
        if (s_reg.cnt == fwsr_pkg::GAP_CYC_C) begin
          s_next.cnt = fwsr_pkg::CNT_ZERO;
          s_next.st  = (s_reg.ph == fwsr_pkg::PH_WRITE) ? fwsr_pkg::ST_WR : fwsr_pkg::ST_RD;
        end
      end
      fwsr_pkg::ST_WR: begin
        s_next.flash_ce_n = 1'b0;
        s_next.flash_we_n = 1'b0;
        s_next.flash_doe  = 1'b1;
        s_next.flash_dout = s_reg.wdata;
        s_next.cnt        = s_reg.cnt + 8'h01;
        if (s_reg.cnt == fwsr_pkg::WRITE_CYC_C) begin
          s_next.flash_ce_n = 1'b1;
          s_next.flash_we_n = 1'b1;
          s_next.cnt        = fwsr_pkg::CNT_ZERO;
          s_next.win_cnt    = 16'(fwsr_pkg::LOAD_WIN_CYC);
          s_next.st         = fwsr_pkg::ST_WR_GAP;
        end
      end
      fwsr_pkg::ST_WR_GAP: begin
        s_next.flash_doe = 1'b0;
        s_next.cnt       = s_reg.cnt + 8'h01;
        if (s_reg.cnt == fwsr_pkg::GAP_CYC_C) begin
          s_next.cnt = fwsr_pkg::CNT_ZERO;
          if (s_reg.flash_addr == fwsr_pkg::RESET_CMD_ADDR && s_reg.wdata == fwsr_pkg::RESET_CMD_DATA) begin
            s_next.failed = 1'b0;
          end
          if (s_reg.add_op) begin
            // second window check: the added sector may have been dropped
            s_next.ph = fwsr_pkg::PH_POST;
            s_next.st = fwsr_pkg::ST_RD;
          end else begin
            s_next.res_code = fwsr_pkg::RES_DONE;
            s_next.st       = fwsr_pkg::ST_DONE;
          end
        end
      end
      fwsr_pkg::ST_DONE: begin
        s_next.res_valid = 1'b1;
        s_next.req_ready = 1'b1;
        s_next.ph        = fwsr_pkg::PH_FIRST;
        s_next.st        = fwsr_pkg::ST_IDLE;
      end
      default: begin
        s_next.st = fwsr_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      s_reg            <= '0;
      s_reg.st         <= fwsr_pkg::ST_IDLE;
      s_reg.ph         <= fwsr_pkg::PH_FIRST;
      s_reg.req_ready  <= 1'b1;
      s_reg.dev_ready  <= 1'b1;
      s_reg.flash_ce_n <= 1'b1;
      s_reg.flash_oe_n <= 1'b1;
      s_reg.flash_we_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign req_ready  = s_reg.req_ready;
  assign res_valid  = s_reg.res_valid;
  assign res_code   = s_reg.res_code;
  assign res_status = s_reg.res_status;
  assign res_late   = s_reg.res_late;
  assign dev_ready  = s_reg.dev_ready;
  assign flash_addr = s_reg.flash_addr;
  assign flash_dout = s_reg.flash_dout;
  assign flash_doe  = s_reg.flash_doe;
  assign flash_ce_n = s_reg.flash_ce_n;
  assign flash_oe_n = s_reg.flash_oe_n;
  assign flash_we_n = s_reg.flash_we_n;
endmodule

// *** hdl/fwsr_pkg.sv ***
// package for the flash write status poller (host side)
// assumes a parallel nor flash with ce/oe/we strobes and an 8-bit data bus
package fwsr_pkg;
  // ==========================================================
  // status bit positions on the data bus
  localparam int unsigned POLL_BIT       = 7;
  localparam int unsigned OP_TOGGLE_BIT  = 6;
  localparam int unsigned TIME_LIMIT_BIT = 5;
  localparam int unsigned ERASE_WIN_BIT  = 3;
  localparam int unsigned SEC_TOGGLE_BIT = 2;
  // ==========================================================
  // widths
  localparam int unsigned ADDR_W = 21;
  localparam int unsigned DATA_W = 8;
  // ==========================================================
  // bus timing, given in ns or us and converted to cycles of sys_clk; GAP_CYC is given in cycles
  localparam int unsigned CLK_MHZ        = 50;
  localparam int unsigned READ_ACCESS_NS = 100;
  localparam int unsigned READ_CYC       = (READ_ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned WRITE_PULSE_NS = 60;
  localparam int unsigned WRITE_CYC      = (WRITE_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned GAP_CYC        = 2;
  localparam int unsigned LOAD_WIN_US    = 50;
  localparam int unsigned LOAD_WIN_CYC   = (LOAD_WIN_US * CLK_MHZ);
  localparam logic [7:0]  CNT_ZERO       = 8'h00;
  localparam logic [7:0]  READ_CYC_C     = 8'(READ_CYC);
  localparam logic [7:0]  WRITE_CYC_C    = 8'(WRITE_CYC);
  localparam logic [7:0]  GAP_CYC_C      = 8'(GAP_CYC);
  // ==========================================================
  // reset command data and address
  localparam logic [7:0]  RESET_CMD_DATA = 8'hf0;
  localparam logic [20:0] RESET_CMD_ADDR = 21'h000000;
  // ==========================================================
  // result codes
  localparam logic [1:0] RES_NONE = 2'h0;
  localparam logic [1:0] RES_DONE = 2'h1;
  localparam logic [1:0] RES_FAIL = 2'h2;
  localparam logic [1:0] RES_WIN  = 2'h3;
  // ==========================================================
  // operations requested by the user
  localparam logic [1:0] OP_POLL  = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_ADD   = 2'h2;
  localparam logic [1:0] OP_RESET = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_RD     = 4'h1,
    ST_RD_GAP = 4'h2,
    ST_WR     = 4'h3,
    ST_WR_GAP = 4'h4,
    ST_DONE   = 4'h5
  } fwsr_state_t;

  typedef enum logic [2:0] {
    PH_FIRST  = 3'h0,
    PH_SECOND = 3'h1,
    PH_RECHK  = 3'h2,
    PH_PRE    = 3'h3,
    PH_POST   = 3'h4,
    PH_WRITE  = 3'h5
  } fwsr_phase_t;
endpackage
